// >>> rtl/mii_xbar_pkg.sv
package mii_xbar_pkg;

  // ****************************************************
  // Register map and field layout
  // ****************************************************
  localparam logic [7:0]  BYPASS_A_OFS  = 8'h17;
  localparam logic [7:0]  BYPASS_B_OFS  = 8'h37;
  localparam logic [7:0]  STATUS_OFS    = 8'h40;
  localparam int          RX_MAP_LO     = 11;
  localparam int          TX_MAP_LO     = 9;
  localparam int          SCMII_RX_BIT  = 7;
  localparam int          SCMII_TX_BIT  = 6;
  localparam int          RMII_EN_BIT   = 5;
  localparam logic [15:0] BYPASS_RESET  = 16'h0000;
  localparam logic [15:0] READ_IDLE     = 16'h0000;

  // ****************************************************
  // Mapping field codes
  // ****************************************************
  localparam logic [1:0]  MAP_NORMAL    = 2'h0;
  localparam logic [1:0]  MAP_OPPOSITE  = 2'h1;
  localparam logic [1:0]  MAP_BOTH      = 2'h2;
  localparam logic [1:0]  MAP_OPP_RX    = 2'h2;
  localparam logic [1:0]  MAP_OFF       = 2'h3;

  // ****************************************************
  // Strap capture timing and widths
  // ****************************************************
  localparam logic [2:0]  STRAP_SETTLE_CYCLES = 3'h4;
  localparam int          STRAP_W             = 10;

  // ****************************************************
  // Types
  // ****************************************************
  typedef struct packed {
    logic       vld;
    logic       err;
    logic [3:0] dat;
  } mii_sym_t;

  localparam mii_sym_t SYM_IDLE = '0;

  typedef struct packed {
    logic [1:0] rx_map;
    logic [1:0] tx_map;
    logic       scmii_rx;
    logic       scmii_tx;
    logic       rmii_en;
  } bypass_t;

  typedef struct packed {
    logic autoneg_en;
    logic speed_100;
    logic full_duplex;
    logic fiber_mode;
  } chan_cfg_t;

  typedef struct packed {
    logic       extender;
    logic       rmii;
    logic [1:0] fiber;
    logic [1:0] autoneg_enable_strap;
    logic [1:0] an_sel0;
    logic [1:0] an_sel1;
  } strap_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    SRC_OWN = 3'b001,
    SRC_OPP = 3'b010,
    SRC_OFF = 3'b100
  } rx_src_t;

  typedef enum logic [2:0] {
    ST_SETTLE = 3'b001,
    ST_APPLY  = 3'b010,
    ST_RUN    = 3'b100
  } strap_state_t;

endpackage

// >>> rtl/strap_sync.sv
`timescale 1ns/100ps
module strap_sync
  import mii_xbar_pkg::*;
#(
  parameter int W = STRAP_W
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  // ****************************************************
  // Three stages per pin, change taken when the last two stages agree
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      logic q_reg;
      assign dout[i] = q_reg;
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          q_reg  <= 1'b0;
        end else begin
          s1_reg <= din[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (s2_reg == s3_reg) begin
            q_reg <= s3_reg;
          end
        end
      end
    end
  endgenerate

endmodule

// >>> rtl/flexible_mii_port_crossbar.sv
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
module flexible_mii_port_crossbar
  import mii_xbar_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire reg_req_t  reg_req,
  output logic [15:0]    reg_rdata,
  input  wire strap_t    strap_pins,
  input  wire mii_sym_t  mac_tx_a,
  input  wire mii_sym_t  mac_tx_b,
  input  wire mii_sym_t  chan_rx_a,
  input  wire mii_sym_t  chan_rx_b,
  output mii_sym_t       mac_rx_a,
  output mii_sym_t       mac_rx_b,
  output mii_sym_t       chan_tx_a,
  output mii_sym_t       chan_tx_b,
  output bypass_t        reduced_iface_bypass_reg_a,
  output bypass_t        reduced_iface_bypass_reg_b,
  output chan_cfg_t      chan_cfg_a,
  output chan_cfg_t      chan_cfg_b
);

  // ****************************************************
  // Declarations
  // ****************************************************
  strap_t       strap_sync_q;
  strap_state_t strap_state_reg;
  logic [2:0]   settle_cnt_reg;
  logic         wr_a;
  logic         wr_b;
  rx_src_t      rx_src_a;
  rx_src_t      rx_src_b;
  mii_sym_t     mac_rx_a_next;
  mii_sym_t     mac_rx_b_next;
  mii_sym_t     chan_tx_a_next;
  mii_sym_t     chan_tx_b_next;
  logic [15:0]  rdata_next;

  // ****************************************************
  // Helpers
  // ****************************************************
  function automatic logic [15:0] pack_bypass(input bypass_t b);
    logic [15:0] w;
    w = 16'h0000;
    w[RX_MAP_LO+1:RX_MAP_LO] = b.rx_map;
    w[TX_MAP_LO+1:TX_MAP_LO] = b.tx_map;
    w[SCMII_RX_BIT] = b.scmii_rx;
    w[SCMII_TX_BIT] = b.scmii_tx;
    w[RMII_EN_BIT] = b.rmii_en;
    return w;
  endfunction
  function automatic bypass_t unpack_bypass(input logic [15:0] w);
    bypass_t b;
    b.rx_map   = w[RX_MAP_LO+1:RX_MAP_LO];
    b.tx_map   = w[TX_MAP_LO+1:TX_MAP_LO];
    b.scmii_rx = w[SCMII_RX_BIT];
    b.scmii_tx = w[SCMII_TX_BIT];
    b.rmii_en  = w[RMII_EN_BIT];
    return b;
  endfunction
  // Which channel feeds a MAC receive port, seen from its master
  function automatic rx_src_t resolve_rx(input logic [1:0] own,
                                         input logic [1:0] opp);
    rx_src_t s;
    s = SRC_OFF;
    if (((opp == MAP_OPPOSITE) || (opp == MAP_BOTH)) &&
        ((own == MAP_OPPOSITE) || (own == MAP_OFF))) begin
      s = SRC_OPP;
    end else if ((own == MAP_BOTH) && (opp == MAP_OPPOSITE)) begin
      s = SRC_OPP;
    end else if ((own == MAP_NORMAL) || (own == MAP_BOTH) ||
                 ((own == MAP_OPPOSITE) && (opp == MAP_NORMAL))) begin
      s = SRC_OWN;
    end
    return s;
  endfunction
  function automatic chan_cfg_t decode_straps(input logic fiber,
                                              input logic autoneg_enable_strap,
                                              input logic sel0,
                                              input logic sel1);
    chan_cfg_t c;
    c.fiber_mode  = fiber;
    c.autoneg_en  = autoneg_enable_strap & ~fiber;
    c.speed_100   = fiber | autoneg_enable_strap | sel0;
    c.full_duplex = fiber | autoneg_enable_strap | sel1;
    return c;
  endfunction

  // ****************************************************
  // Strap capture after reset release
  // ****************************************************
  strap_sync #(
    .W (STRAP_W)
  ) u_strap_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .din   (strap_pins),
    .dout  (strap_sync_q)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_state_reg <= ST_SETTLE;
      settle_cnt_reg  <= 3'h0;
    end else begin
      case (strap_state_reg)
        ST_SETTLE: begin
          settle_cnt_reg <= settle_cnt_reg + 3'h1;
          if (settle_cnt_reg == STRAP_SETTLE_CYCLES) begin
            strap_state_reg <= ST_APPLY;
          end
        end
        ST_APPLY, ST_RUN: strap_state_reg <= ST_RUN;
        default:          strap_state_reg <= ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_cfg_a <= '0;
      chan_cfg_b <= '0;
    end else if (strap_state_reg == ST_APPLY) begin
      chan_cfg_a <= decode_straps(strap_sync_q.fiber[0],
                                  strap_sync_q.autoneg_enable_strap[0],
                                  strap_sync_q.an_sel0[0],
                                  strap_sync_q.an_sel1[0]);
      chan_cfg_b <= decode_straps(strap_sync_q.fiber[1],
                                  strap_sync_q.autoneg_enable_strap[1],
                                  strap_sync_q.an_sel0[1],
                                  strap_sync_q.an_sel1[1]);
    end
  end

  // ****************************************************
  // Bypass control registers
  // ****************************************************
  assign wr_a = reg_req.wr && (reg_req.addr == BYPASS_A_OFS);
  assign wr_b = reg_req.wr && (reg_req.addr == BYPASS_B_OFS);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reduced_iface_bypass_reg_a <= unpack_bypass(BYPASS_RESET);
      reduced_iface_bypass_reg_b <= unpack_bypass(BYPASS_RESET);
    end else if (strap_state_reg == ST_APPLY) begin
      reduced_iface_bypass_reg_a.rmii_en <= strap_sync_q.rmii;
      reduced_iface_bypass_reg_b.rmii_en <= strap_sync_q.rmii;
      if (strap_sync_q.extender) begin
        reduced_iface_bypass_reg_a.rx_map <= MAP_OFF;
        reduced_iface_bypass_reg_a.tx_map <= MAP_OPP_RX;
        reduced_iface_bypass_reg_b.rx_map <= MAP_OFF;
        reduced_iface_bypass_reg_b.tx_map <= MAP_OPP_RX;
        reduced_iface_bypass_reg_a.scmii_rx <= ~strap_sync_q.rmii;
        reduced_iface_bypass_reg_a.scmii_tx <= ~strap_sync_q.rmii;
        reduced_iface_bypass_reg_b.scmii_rx <= ~strap_sync_q.rmii;
        reduced_iface_bypass_reg_b.scmii_tx <= ~strap_sync_q.rmii;
      end
    end else begin
      if (wr_a) begin
        reduced_iface_bypass_reg_a <= unpack_bypass(reg_req.wdata);
      end
      if (wr_b) begin
        reduced_iface_bypass_reg_b <= unpack_bypass(reg_req.wdata);
      end
    end
  end

  // ****************************************************
  // Register read port
  // ****************************************************
  always_comb begin
    rdata_next = READ_IDLE;
    if (reg_req.rd && (reg_req.addr == BYPASS_A_OFS)) begin
      rdata_next = pack_bypass(reduced_iface_bypass_reg_a);
    end else if (reg_req.rd && (reg_req.addr == BYPASS_B_OFS)) begin
      rdata_next = pack_bypass(reduced_iface_bypass_reg_b);
    end else if (reg_req.rd && (reg_req.addr == STATUS_OFS)) begin
      rdata_next = {7'h00, strap_sync_q.extender, (strap_state_reg == ST_RUN),
                    1'b0, rx_src_b, rx_src_a};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= READ_IDLE;
    end else begin
      reg_rdata <= rdata_next;
    end
  end

  // ****************************************************
  // Receive routing
  // ****************************************************
  // source resolution
  assign rx_src_a = resolve_rx(reduced_iface_bypass_reg_a.rx_map,
                               reduced_iface_bypass_reg_b.rx_map);
  assign rx_src_b = resolve_rx(reduced_iface_bypass_reg_b.rx_map,
                               reduced_iface_bypass_reg_a.rx_map);

  always_comb begin
    case (rx_src_a)
      SRC_OWN: mac_rx_a_next = chan_rx_a;
      SRC_OPP: mac_rx_a_next = chan_rx_b;
      default: mac_rx_a_next = SYM_IDLE;
    endcase
    case (rx_src_b)
      SRC_OWN: mac_rx_b_next = chan_rx_b;
      SRC_OPP: mac_rx_b_next = chan_rx_a;
      default: mac_rx_b_next = SYM_IDLE;
    endcase
  end

  // ****************************************************
  // Transmit routing
  // ****************************************************
  // transmit source select
  always_comb begin
    case (reduced_iface_bypass_reg_a.tx_map)
      MAP_NORMAL:   chan_tx_a_next = mac_tx_a;
      MAP_OPPOSITE: chan_tx_a_next = mac_tx_b;
      MAP_OPP_RX:   chan_tx_a_next = chan_rx_b;
      default:      chan_tx_a_next = SYM_IDLE;
    endcase
    case (reduced_iface_bypass_reg_b.tx_map)
      MAP_NORMAL:   chan_tx_b_next = mac_tx_b;
      MAP_OPPOSITE: chan_tx_b_next = mac_tx_a;
      MAP_OPP_RX:   chan_tx_b_next = chan_rx_a;
      default:      chan_tx_b_next = SYM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mac_rx_a  <= SYM_IDLE;
      mac_rx_b  <= SYM_IDLE;
      chan_tx_a <= SYM_IDLE;
      chan_tx_b <= SYM_IDLE;
    end else begin
      mac_rx_a  <= mac_rx_a_next;
      mac_rx_b  <= mac_rx_b_next;
      chan_tx_a <= chan_tx_a_next;
      chan_tx_b <= chan_tx_b_next;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [3:0] map_a;
  logic [3:0] map_b;
  assign map_a = {reduced_iface_bypass_reg_a.rx_map,
                  reduced_iface_bypass_reg_a.tx_map};
  assign map_b = {reduced_iface_bypass_reg_b.rx_map,
                  reduced_iface_bypass_reg_b.tx_map};

  AST_RX_BOTH_OFF: assert property (
    (reduced_iface_bypass_reg_a.rx_map == MAP_OFF &&
     reduced_iface_bypass_reg_b.rx_map == MAP_OFF)
    |=> (mac_rx_a == SYM_IDLE && mac_rx_b == SYM_IDLE))
    else $error("Disabled receive ports not idle");
  AST_RX_OPP_YIELD: assert property (
    (reduced_iface_bypass_reg_a.rx_map == MAP_OPPOSITE &&
     reduced_iface_bypass_reg_b.rx_map == MAP_NORMAL)
    |=> (mac_rx_a == $past(chan_rx_a) && mac_rx_b == $past(chan_rx_b)))
    else $error("Opposite request not yielded to master");
  AST_TX_OPP_RX: assert property (
    reduced_iface_bypass_reg_a.tx_map == MAP_OPP_RX
    |=> chan_tx_a == $past(chan_rx_b))
    else $error("Channel A not sending channel B receive data");
  AST_NORMAL: assert property (
    (map_a == 4'h0 && map_b == 4'h0)
    |=> (mac_rx_a == $past(chan_rx_a) && chan_tx_b == $past(mac_tx_b)))
    else $error("Normal mapping not straight through");
  AST_SWAP: assert property (
    (map_a == 4'h5 && map_b == 4'h5)
    |=> (mac_rx_a == $past(chan_rx_b) && chan_tx_a == $past(mac_tx_b)))
    else $error("Swap mapping wrong");
  AST_EXTENDER: assert property (
    (map_a == 4'hE && map_b == 4'hE)
    |=> (mac_rx_b == SYM_IDLE && chan_tx_b == $past(chan_rx_a)))
    else $error("Extender mapping wrong");
  AST_BCAST_A: assert property (
    (reduced_iface_bypass_reg_a.tx_map == MAP_NORMAL &&
     reduced_iface_bypass_reg_b.tx_map == MAP_OPPOSITE)
    |=> (chan_tx_a == $past(mac_tx_a) && chan_tx_b == $past(mac_tx_a)))
    else $error("Broadcast from port A wrong");
  AST_BCAST_B: assert property (
    (reduced_iface_bypass_reg_a.tx_map == MAP_OPPOSITE &&
     reduced_iface_bypass_reg_b.tx_map == MAP_NORMAL)
    |=> (chan_tx_a == $past(mac_tx_b) && chan_tx_b == $past(mac_tx_b)))
    else $error("Broadcast from port B wrong");
  AST_MIRROR_A: assert property (
    (reduced_iface_bypass_reg_a.rx_map == MAP_BOTH &&
     reduced_iface_bypass_reg_b.rx_map == MAP_OFF)
    |=> (mac_rx_a == $past(chan_rx_a) && mac_rx_b == $past(chan_rx_a)))
    else $error("Mirror of channel A wrong");
  AST_MIRROR_B: assert property (
    (reduced_iface_bypass_reg_a.rx_map == MAP_OFF &&
     reduced_iface_bypass_reg_b.rx_map == MAP_BOTH)
    |=> (mac_rx_a == $past(chan_rx_b) && mac_rx_b == $past(chan_rx_b)))
    else $error("Mirror of channel B wrong");
  AST_PORT_A_OFF: assert property (
    map_a == 4'hF |=> (chan_tx_a == SYM_IDLE &&
      (mac_rx_a == SYM_IDLE || mac_rx_a == $past(chan_rx_b))))
    else $error("Port A carries channel A while disabled");
  AST_PORT_B_OFF: assert property (
    map_b == 4'hF |=> (chan_tx_b == SYM_IDLE &&
      (mac_rx_b == SYM_IDLE || mac_rx_b == $past(chan_rx_a))))
    else $error("Port B carries channel B while disabled");
  AST_STRAP_EXT: assert property (
    (strap_state_reg == ST_APPLY && strap_sync_q.extender)
    |=> (map_a == 4'hE && map_b == 4'hE) ##1 strap_state_reg == ST_RUN)
    else $error("Extender strap did not cross-connect");
  AST_STRAP_SCMII: assert property (
    (strap_state_reg == ST_APPLY && strap_sync_q.extender &&
     !strap_sync_q.rmii)
    |=> (reduced_iface_bypass_reg_a.scmii_rx &&
         reduced_iface_bypass_reg_b.scmii_tx))
    else $error("Single-clock mode not set by extender strap");
  AST_REG_WRITE: assert property (
    (wr_a && strap_state_reg == ST_RUN)
    |=> (pack_bypass(reduced_iface_bypass_reg_a) ==
         ($past(reg_req.wdata) & 16'h1EE0)))
    else $error("Bypass register A write lost");

  COV_NORMAL: cover property (map_a == 4'h0 && map_b == 4'h0);
  COV_EXTENDER: cover property (map_a == 4'hE && map_b == 4'hE);
  COV_MIRROR_A: cover property (
    reduced_iface_bypass_reg_a.rx_map == MAP_BOTH &&
    reduced_iface_bypass_reg_b.rx_map == MAP_OFF);
  COV_STRAP: cover property (
    strap_state_reg == ST_APPLY && strap_sync_q.extender);

endmodule

// >>> verification/mac_model.sv
`timescale 1ns/100ps
module mac_model
  import mii_xbar_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rst_b,
  input  wire mii_sym_t mac_rx_a,
  input  wire mii_sym_t mac_rx_b,
  output mii_sym_t      mac_tx_a,
  output mii_sym_t      mac_tx_b
);
  logic [3:0]  nib_reg;
  logic [15:0] rx_seen_reg;

  // ****************************************************
  // Transmit stream, new symbol every clock
  // ****************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nib_reg  <= 4'h0;
      mac_tx_a <= SYM_IDLE;
      mac_tx_b <= SYM_IDLE;
    end else begin
      nib_reg  <= nib_reg + 4'h1;
      mac_tx_a <= '{vld: 1'b1, err: nib_reg[3], dat: nib_reg};
      mac_tx_b <= '{vld: nib_reg[0], err: 1'b0, dat: ~nib_reg};
    end
  end

  // Count of valid symbols received
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_seen_reg <= 16'h0000;
    end else begin
      rx_seen_reg <= rx_seen_reg + 16'(mac_rx_a.vld) + 16'(mac_rx_b.vld);
    end
  end
endmodule

// >>> verification/tb_flexible_mii_port_crossbar.sv
`timescale 1ns/100ps
module tb_flexible_mii_port_crossbar
  import mii_xbar_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b;
  reg_req_t    reg_req;
  logic [15:0] reg_rdata;
  strap_t      strap_pins;
  mii_sym_t    mac_tx_a, mac_tx_b, mac_rx_a, mac_rx_b;
  mii_sym_t    chan_rx_a = '0;
  mii_sym_t    chan_rx_b = '0;
  mii_sym_t    chan_tx_a, chan_tx_b;
  mii_sym_t    p_mtx_a, p_mtx_b, p_crx_a, p_crx_b;
  bypass_t     byp_a, byp_b;
  chan_cfg_t   cfg_a, cfg_b;
  logic [3:0]  cnt = 4'h0;
  logic [15:0] rd;
  int          failures = 0;
  int          num_checks = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  flexible_mii_port_crossbar u_dut (
    .clk(clk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .strap_pins(strap_pins), .mac_tx_a(mac_tx_a), .mac_tx_b(mac_tx_b),
    .chan_rx_a(chan_rx_a), .chan_rx_b(chan_rx_b), .mac_rx_a(mac_rx_a),
    .mac_rx_b(mac_rx_b), .chan_tx_a(chan_tx_a), .chan_tx_b(chan_tx_b),
    .reduced_iface_bypass_reg_a(byp_a), .reduced_iface_bypass_reg_b(byp_b),
    .chan_cfg_a(cfg_a), .chan_cfg_b(cfg_b));

  mac_model u_mac (
    .clk(clk), .rst_b(rst_b), .mac_rx_a(mac_rx_a), .mac_rx_b(mac_rx_b),
    .mac_tx_a(mac_tx_a), .mac_tx_b(mac_tx_b));

  // ****************************************************
  // Channel receive stream and input history
  // ****************************************************
  always @(posedge clk) begin
    cnt       <= cnt + 4'h1;
    chan_rx_a <= '{vld: 1'b1, err: cnt[2], dat: cnt + 4'h5};
    chan_rx_b <= '{vld: cnt[1], err: 1'b1, dat: cnt ^ 4'hA};
    p_mtx_a   <= mac_tx_a;
    p_mtx_b   <= mac_tx_b;
    p_crx_a   <= chan_rx_a;
    p_crx_b   <= chan_rx_b;
  end

  // ****************************************************
  // Helpers
  // ****************************************************
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Reset with new straps, wait until the strap load is done
  task automatic reset_with(input strap_t s);
    @(posedge clk);
    rst_b      <= 1'b0;
    strap_pins <= s;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic [15:0] map_word(input logic [1:0] r,
                                           input logic [1:0] t);
    return {3'h0, r, t, 1'b0, 2'b11, 6'h00};
  endfunction

  function automatic mii_sym_t rx_exp(input logic [1:0] own,
    input logic [1:0] opp, input mii_sym_t s_own, input mii_sym_t s_opp);
    if (((opp == MAP_OPPOSITE || opp == MAP_BOTH) &&
         (own == MAP_OPPOSITE || own == MAP_OFF)) ||
        (own == MAP_BOTH && opp == MAP_OPPOSITE))
      return s_opp;
    if (own == MAP_NORMAL || own == MAP_BOTH ||
        (own == MAP_OPPOSITE && opp == MAP_NORMAL))
      return s_own;
    return '0;
  endfunction

  function automatic mii_sym_t tx_exp(input logic [1:0] t,
    input mii_sym_t m_own, input mii_sym_t m_opp, input mii_sym_t r_opp);
    case (t)
      MAP_NORMAL:   return m_own;
      MAP_OPPOSITE: return m_opp;
      MAP_OPP_RX:   return r_opp;
      default:      return '0;
    endcase
  endfunction

  task automatic check_paths(input logic [1:0] ra, input logic [1:0] ta,
                             input logic [1:0] rb, input logic [1:0] tb);
    repeat (3) @(posedge clk);
    repeat (2) begin
      @(negedge clk);
      check("mac_rx_a", {10'h000, mac_rx_a},
            {10'h000, rx_exp(ra, rb, p_crx_a, p_crx_b)});
      check("mac_rx_b", {10'h000, mac_rx_b},
            {10'h000, rx_exp(rb, ra, p_crx_b, p_crx_a)});
      check("chan_tx_a", {10'h000, chan_tx_a},
            {10'h000, tx_exp(ta, p_mtx_a, p_mtx_b, p_crx_b)});
      check("chan_tx_b", {10'h000, chan_tx_b},
            {10'h000, tx_exp(tb, p_mtx_b, p_mtx_a, p_crx_a)});
    end
  endtask

  task automatic run_map(input logic [1:0] ra, input logic [1:0] ta,
                         input logic [1:0] rb, input logic [1:0] tb);
    wr_reg(BYPASS_A_OFS, map_word(ra, ta));
    wr_reg(BYPASS_B_OFS, map_word(rb, tb));
    @(negedge clk);
    check("bypass_a", {9'h000, byp_a}, {9'h000, ra, ta, 3'b110});
    check_paths(ra, ta, rb, tb);
  endtask

  // ****************************************************
  // Watchdog
  // ****************************************************
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end

  // ****************************************************
  // Test sequence
  // ****************************************************
  initial begin
    strap_pins = '{extender: 1'b1, rmii: 1'b0, fiber: 2'b01, autoneg_enable_strap: 2'b00,
                   an_sel0: 2'b10, an_sel1: 2'b10};
    reg_req = '0;
    rst_b = 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (12) @(posedge clk);
    @(negedge clk);
    check("cfg_a", {12'h000, cfg_a}, 16'h0007);
    check("cfg_b", {12'h000, cfg_b}, 16'h0006);
    check("bypass_a", {9'h000, byp_a}, 16'h0076);
    check("bypass_b", {9'h000, byp_b}, 16'h0076);
    rd_reg(BYPASS_A_OFS, rd);
    check("read_a", rd, 16'h1CC0);
    rd_reg(STATUS_OFS, rd);
    check("status", rd, 16'h01A4);
    check_paths(2'h3, 2'h2, 2'h3, 2'h2);
    run_map(2'h0, 2'h0, 2'h0, 2'h0);
    run_map(2'h1, 2'h1, 2'h1, 2'h1);
    run_map(2'h3, 2'h2, 2'h3, 2'h2);
    run_map(2'h1, 2'h0, 2'h2, 2'h1);
    run_map(2'h0, 2'h1, 2'h3, 2'h0);
    run_map(2'h2, 2'h3, 2'h3, 2'h0);
    run_map(2'h3, 2'h0, 2'h2, 2'h2);
    run_map(2'h3, 2'h3, 2'h1, 2'h0);
    run_map(2'h2, 2'h0, 2'h3, 2'h3);
    for (int i = 0; i < 256; i++) begin
      run_map(i[7:6], i[5:4], i[3:2], i[1:0]);
    end
    rd_reg(BYPASS_B_OFS, rd);
    check("read_b", rd, 16'h1EC0);
    rd_reg(8'h20, rd);
    check("read_unmapped", rd, 16'h0000);
    reset_with('{extender: 1'b0, rmii: 1'b1, fiber: 2'b00,
                 autoneg_enable_strap: 2'b01, an_sel0: 2'b00, an_sel1: 2'b10});
    check("cfg_a", {12'h000, cfg_a}, 16'h000E);
    check("cfg_b", {12'h000, cfg_b}, 16'h0002);
    check("bypass_a", {9'h000, byp_a}, 16'h0001);
    check("bypass_b", {9'h000, byp_b}, 16'h0001);
    check_paths(2'h0, 2'h0, 2'h0, 2'h0);
    reset_with('{extender: 1'b1, rmii: 1'b1, fiber: 2'b11,
                 autoneg_enable_strap: 2'b00, an_sel0: 2'b00, an_sel1: 2'b00});
    check("cfg_a", {12'h000, cfg_a}, 16'h0007);
    check("cfg_b", {12'h000, cfg_b}, 16'h0007);
    check("bypass_a", {9'h000, byp_a}, 16'h0071);
    check("bypass_b", {9'h000, byp_b}, 16'h0071);
    check_paths(2'h3, 2'h2, 2'h3, 2'h2);
    summarize();
  end
endmodule
